//--- cosi_pkg.sv
// cosi_pkg: constants and types shared by the status indicator block.
// assumes a single 200 MHz clock domain.
package cosi_pkg;

	// clock rate
	localparam int unsigned CLK_HZ          = 200_000_000;

	// default pattern times in microseconds (programmable at run time)
	localparam int unsigned FLASH_ON_US     = 200;
	localparam int unsigned FLASH_OFF_US    = 1000;
	localparam int unsigned BLINK_US        = 200;
	localparam int unsigned GAP_US          = 200;

	// derived cycle counts, microseconds times clock cycles per microsecond
	localparam int unsigned FLASH_ON_CYC  = FLASH_ON_US * (CLK_HZ / 1_000_000);
	localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BLINK_CYC     = BLINK_US * (CLK_HZ / 1_000_000);
	localparam int unsigned GAP_CYC       = GAP_US * (CLK_HZ / 1_000_000);

	// counter width for pattern timings
	localparam int unsigned TIME_W        = 24;

	// node id range and reset value
	localparam logic [6:0] NODE_ID_MIN    = 7'h01;
	localparam logic [6:0] NODE_ID_MAX    = 7'h7f;
	localparam logic [6:0] NODE_ID_RST    = 7'h01;

	// bit rate selector codes
	typedef enum logic [2:0] {
		COSI_RATE_10K,
		COSI_RATE_20K,
		COSI_RATE_50K,
		COSI_RATE_125K,
		COSI_RATE_250K,
		COSI_RATE_500K,
		COSI_RATE_800K,
		COSI_RATE_1M
	} cosi_rate_type;
	localparam logic [2:0] RATE_RST       = 3'h3;

	// network state machine encoding on the input port
	typedef enum logic [1:0] {
		COSI_NMT_INIT,
		COSI_NMT_PREOP,
		COSI_NMT_STOPPED,
		COSI_NMT_OPER
	} cosi_nmt_type;

	// light patterns
	typedef enum logic [2:0] {
		COSI_PAT_OFF,
		COSI_PAT_SINGLE,
		COSI_PAT_DOUBLE,
		COSI_PAT_BLINK,
		COSI_PAT_ON
	} cosi_pat_type;

endpackage

//--- cosi_sync.sv
// cosi_sync: three flip-flop input synchroniser with agreement check.
// assumes inputs from outside the clock domain; rst_n already synchronised.
module cosi_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;
	wire  [WIDTH-1:0] agree_w = ~(s2_q ^ s3_q);
	wire  [WIDTH-1:0] out_d   = (agree_w & s3_q) | (~agree_w & out_q);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q  <= async_i;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_o = out_q;

endmodule

//--- cosi_pattern.sv
// cosi_pattern: generates one light pattern (off, flash, double, blink, on).
// assumes period counts are at least one; changes apply to the running phase at once.
module cosi_pattern #(
	parameter int unsigned TW = cosi_pkg::TIME_W
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	// pattern select and timings
	input  cosi_pkg::cosi_pat_type pat_i,
	input  wire logic [TW-1:0] on_cyc_i,
	input  wire logic [TW-1:0] off_cyc_i,
	input  wire logic [TW-1:0] blink_cyc_i,
	input  wire logic [TW-1:0] gap_cyc_i,
	// lamp
	output logic               lit_o
);

	// phase: 0 first flash, 1 gap, 2 second flash, 3 long off
	logic [1:0]    phase_q;
	logic [1:0]    phase_d;
	logic [TW-1:0] cnt_q;
	logic [TW-1:0] cnt_d;
	logic          lit_q;
	logic          lit_d;
	logic [TW-1:0] len_w;
	wire           done_w = (cnt_q >= len_w - TW'(1));
	wire           blink_w = (pat_i == cosi_pkg::COSI_PAT_BLINK);
	wire           dbl_w   = (pat_i == cosi_pkg::COSI_PAT_DOUBLE);

	always_comb begin
		case (phase_q)
		2'd0: len_w = blink_w ? blink_cyc_i : on_cyc_i;
		2'd1: len_w = gap_cyc_i;
		2'd2: len_w = on_cyc_i;
		default: len_w = blink_w ? blink_cyc_i : off_cyc_i;
		endcase
	end

	always_comb begin
		cnt_d   = done_w ? '0 : cnt_q + TW'(1);
		phase_d = phase_q;
		if (done_w) begin
			case (phase_q)
			2'd0: phase_d = dbl_w ? 2'd1 : 2'd3;
			2'd1: phase_d = 2'd2;
			2'd2: phase_d = 2'd3;
			default: phase_d = 2'd0;
			endcase
		end
		if (pat_i == cosi_pkg::COSI_PAT_OFF || pat_i == cosi_pkg::COSI_PAT_ON) begin
			cnt_d   = '0;
			phase_d = 2'd0;
		end
		case (pat_i)
		cosi_pkg::COSI_PAT_ON: lit_d = 1'b1;
		cosi_pkg::COSI_PAT_OFF: lit_d = 1'b0;
		default: lit_d = (phase_d == 2'd0) || (phase_d == 2'd2);
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_q <= 2'd0;
			cnt_q   <= '0;
			lit_q   <= 1'b0;
		end else begin
			phase_q <= phase_d;
			cnt_q   <= cnt_d;
			lit_q   <= lit_d;
		end
	end

	assign lit_o = lit_q;

endmodule

//--- cosi_top.sv
// cosi_top: bus status indicator and node settings of a field-bus slave.
// assumes the protocol engine supplies status levels and a setting strobe.
//
// Overview of operation
// RQ1 - red stays dark when no bus or error-control fault is active.
// RQ2 - red shows a single flash when an error counter reached the warning level.
// RQ3 - red shows a double flash after a guarding or heartbeat timeout event.
// RQ4 - red stays lit while the controller is bus off.
// RQ5 - of several faults only the highest numbered one is shown.
// RQ6 - red covers both physical-layer status and missing-message faults.
// RQ7 - green blinks continuously in the preoperational state.
// RQ8 - green shows a single flash in the stopped state.
// RQ9 - green stays lit in the operational state.
// RQ10 - green stays dark before the bus connects and during any reset.
// RQ11 - when red and green conflict the lamp shows red, else both combine.
// RQ12 - bit rate is a software setting chosen from eight codes.
// RQ13 - node id is a software setting accepted only from 1 to 127.
// RQ14 - all pattern timings come from programmable cycle counts.
module cosi_top #(
	parameter int unsigned TW        = cosi_pkg::TIME_W,
	parameter int unsigned ON_CYC    = cosi_pkg::FLASH_ON_CYC,
	parameter int unsigned OFF_CYC   = cosi_pkg::FLASH_OFF_CYC,
	parameter int unsigned BLINK_CYC = cosi_pkg::BLINK_CYC,
	parameter int unsigned GAP_CYC   = cosi_pkg::GAP_CYC
) (
	// clock and reset
	input  wire logic          clock_i,
	input  wire logic          arst_n_i,
	// controller status levels from outside the domain
	input  wire logic          warn_i,
	input  wire logic          bus_off_i,
	input  wire logic          connected_i,
	input  wire logic          node_reset_i,
	// error-control event pulses and acknowledge, same domain
	input  wire logic          ctl_event_i,
	input  wire logic          ctl_clear_i,
	// network state, same domain
	input  wire logic [1:0]    nmt_state_i,
	// settings, same domain
	input  wire logic          set_wr_i,
	input  wire logic [2:0]    set_rate_i,
	input  wire logic [6:0]    set_id_i,
	input  wire logic          tim_wr_i,
	input  wire logic [TW-1:0] tim_on_i,
	input  wire logic [TW-1:0] tim_off_i,
	input  wire logic [TW-1:0] tim_blink_i,
	input  wire logic [TW-1:0] tim_gap_i,
	// lamp and settings out
	output logic               led_red_o,
	output logic               led_green_o,
	output logic [2:0]         rate_o,
	output logic [6:0]         node_id_o,
	output logic               id_reject_o
);

	// reset release
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// pin level inputs
	logic [3:0] lvl_w;
	cosi_sync #(
		.WIDTH (4)
	) u_sync (
		.clk_i   (clock_i),
		.rst_n_i (rst_n_q),
		.async_i ({warn_i, bus_off_i, connected_i, node_reset_i}),
		.sync_o  (lvl_w)
	);
	wire warn_w   = lvl_w[3];
	wire busoff_w = lvl_w[2];
	wire conn_w   = lvl_w[1];
	wire nrst_w   = lvl_w[0];

	// sticky error-control event; set wins over clear
	logic ctl_q;
	wire  ctl_d = ctl_event_i | (ctl_q & ~ctl_clear_i);

	// settings
	logic [2:0]    rate_q;
	logic [6:0]    id_q;
	logic          rej_q;
	wire           id_ok_w = (set_id_i >= cosi_pkg::NODE_ID_MIN) &&
	                         (set_id_i <= cosi_pkg::NODE_ID_MAX);
	wire  [6:0]    id_d    = (set_wr_i && id_ok_w) ? set_id_i : id_q; // RQ13
	wire  [2:0]    rate_d  = set_wr_i ? set_rate_i : rate_q; // RQ12
	wire           rej_d   = set_wr_i ? ~id_ok_w : rej_q;

	// programmable timings
	logic [TW-1:0] on_q;
	logic [TW-1:0] off_q;
	logic [TW-1:0] blink_q;
	logic [TW-1:0] gap_q;
	wire  [TW-1:0] fix_on_w    = (tim_on_i == '0) ? TW'(1) : tim_on_i;
	wire  [TW-1:0] fix_off_w   = (tim_off_i == '0) ? TW'(1) : tim_off_i;
	wire  [TW-1:0] fix_blink_w = (tim_blink_i == '0) ? TW'(1) : tim_blink_i;
	wire  [TW-1:0] fix_gap_w   = (tim_gap_i == '0) ? TW'(1) : tim_gap_i;

	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctl_q   <= 1'b0;
			rate_q  <= cosi_pkg::RATE_RST;
			id_q    <= cosi_pkg::NODE_ID_RST;
			rej_q   <= 1'b0;
			on_q    <= TW'(ON_CYC);
			off_q   <= TW'(OFF_CYC);
			blink_q <= TW'(BLINK_CYC);
			gap_q   <= TW'(GAP_CYC);
		end else begin
			ctl_q   <= ctl_d; // RQ3
			rate_q  <= rate_d;
			id_q    <= id_d;
			rej_q   <= rej_d;
			if (tim_wr_i) begin
				on_q    <= fix_on_w; // RQ14
				off_q   <= fix_off_w;
				blink_q <= fix_blink_w;
				gap_q   <= fix_gap_w;
			end
		end
	end

	// red pattern: highest numbered fault wins
	cosi_pkg::cosi_pat_type red_pat_w;
	always_comb begin
		if (busoff_w)
			red_pat_w = cosi_pkg::COSI_PAT_ON; // RQ4 RQ5
		else if (ctl_q)
			red_pat_w = cosi_pkg::COSI_PAT_DOUBLE; // RQ3 RQ6
		else if (warn_w)
			red_pat_w = cosi_pkg::COSI_PAT_SINGLE; // RQ2 RQ6
		else
			red_pat_w = cosi_pkg::COSI_PAT_OFF; // RQ1
	end

	// green pattern from network state
	cosi_pkg::cosi_pat_type grn_pat_w;
	always_comb begin
		if (!conn_w || nrst_w)
			grn_pat_w = cosi_pkg::COSI_PAT_OFF; // RQ10
		else begin
			case (cosi_pkg::cosi_nmt_type'(nmt_state_i))
			cosi_pkg::COSI_NMT_PREOP: grn_pat_w = cosi_pkg::COSI_PAT_BLINK; // RQ7
			cosi_pkg::COSI_NMT_STOPPED: grn_pat_w = cosi_pkg::COSI_PAT_SINGLE; // RQ8
			cosi_pkg::COSI_NMT_OPER: grn_pat_w = cosi_pkg::COSI_PAT_ON; // RQ9
			default: grn_pat_w = cosi_pkg::COSI_PAT_OFF;
			endcase
		end
	end

	logic red_lit_w;
	logic grn_lit_w;
	cosi_pattern #(
		.TW (TW)
	) u_red (
		.clk_i       (clock_i),
		.rst_n_i     (rst_n_q),
		.pat_i       (red_pat_w),
		.on_cyc_i    (on_q),
		.off_cyc_i   (off_q),
		.blink_cyc_i (blink_q),
		.gap_cyc_i   (gap_q),
		.lit_o       (red_lit_w)
	);
	cosi_pattern #(
		.TW (TW)
	) u_grn (
		.clk_i       (clock_i),
		.rst_n_i     (rst_n_q),
		.pat_i       (grn_pat_w),
		.on_cyc_i    (on_q),
		.off_cyc_i   (off_q),
		.blink_cyc_i (blink_q),
		.gap_cyc_i   (gap_q),
		.lit_o       (grn_lit_w)
	);

	// bicolour lamp: red lit forces green dark
	wire red_d = red_lit_w;
	wire grn_d = grn_lit_w & ~red_lit_w; // RQ11
	logic red_q;
	logic grn_q;
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			red_q <= 1'b0;
			grn_q <= 1'b0;
		end else begin
			red_q <= red_d;
			grn_q <= grn_d;
		end
	end

	assign led_red_o   = red_q;
	assign led_green_o = grn_q;
	assign rate_o      = rate_q;
	assign node_id_o   = id_q;
	assign id_reject_o = rej_q;

endmodule

//--- cosi_master_model.sv
// cosi_master_model: network master as seen from the node, behavioural.
// assumes bench commands change just after a rising edge.
module cosi_master_model (
	// clock
	input  wire logic       clk_i,
	// bench commands
	input  wire logic       link_i,
	input  wire logic [1:0] cmd_i,
	input  wire logic       miss_i,
	// towards the node
	output logic            conn_o,
	output logic [1:0]      nmt_o,
	output logic            event_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {conn_o, nmt_o, event_o} = 4'h0;
	// a missed guard reply shows as a one-cycle event
	always @(posedge clk_i) begin
		conn_o <= link_i;
		nmt_o <= cmd_i;
		event_o <= miss_i;
	end
endmodule

//--- cosi_top_monitor.sv
// cosi_top_monitor: port assertions for the status indicator.
// assumes it is bound to cosi_top and sampled on clock_i.
module cosi_top_monitor (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       arst_n_i,
	// status and settings in
	input wire logic       warn_i,
	input wire logic       bus_off_i,
	input wire logic       connected_i,
	input wire logic       node_reset_i,
	input wire logic       ctl_event_i,
	input wire logic       ctl_clear_i,
	input wire logic [1:0] nmt_state_i,
	input wire logic       set_wr_i,
	input wire logic [2:0] set_rate_i,
	input wire logic [6:0] set_id_i,
	// lamp and settings out
	input wire logic       led_red_o,
	input wire logic       led_green_o,
	input wire logic [2:0] rate_o,
	input wire logic [6:0] node_id_o,
	input wire logic       id_reject_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	red_dark_a: assert property (
		ctl_clear_i ##0 (!warn_i && !bus_off_i && !ctl_event_i) [*8]
		|=> !led_red_o) else $error("red lit without fault");
	red_busoff_a: assert property (
		bus_off_i [*8] |=> led_red_o && !led_green_o)
		else $error("bus off not shown");
	red_wins_a: assert property (
		led_green_o |-> !led_red_o) else $error("both colours lit");
	grn_dark_a: assert property (
		(!connected_i || node_reset_i) [*8] |=> !led_green_o)
		else $error("green lit while unconnected");
	grn_init_a: assert property (
		(nmt_state_i == 2'h0) [*4] |=> !led_green_o)
		else $error("green lit in init");
	grn_oper_a: assert property (
		(connected_i && !node_reset_i && nmt_state_i == 2'h3) [*8]
		|=> led_green_o || led_red_o) else $error("lamp dark in oper");
	id_reject_a: assert property (
		set_wr_i && set_id_i == 7'h00 |=> id_reject_o && $stable(node_id_o))
		else $error("id zero taken");
	id_take_a: assert property (
		set_wr_i && set_id_i != 7'h00
		|=> node_id_o == $past(set_id_i) && !id_reject_o)
		else $error("id not taken");
	rate_take_a: assert property (
		set_wr_i |=> rate_o == $past(set_rate_i)) else $error("rate not taken");
	set_hold_a: assert property (
		!set_wr_i |=> $stable(rate_o) && $stable(node_id_o))
		else $error("setting moved");
endmodule

//--- cosi_top_tb.sv
// cosi_top_tb: self-checking bench for the status indicator.
// assumes cosi_pkg, cosi_top, the master model and monitor compile first.
module cosi_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, arst_n, warn, bus_off, nreset, clr, set_wr, tim_wr;
	logic        link, miss, conn, evt, red, grn, rej;
	logic [1:0]  cmd, nmt;
	logic [2:0]  rate_in, rate;
	logic [6:0]  id_in, id;
	logic [23:0] t_on, t_off, t_blk, t_gap;
	logic [31:0] cnt;
	int          errors, check_count;

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	cosi_top #(.ON_CYC(4), .OFF_CYC(8), .BLINK_CYC(4), .GAP_CYC(2)) u_dut (
		.clock_i(clk), .arst_n_i(arst_n), .warn_i(warn), .bus_off_i(bus_off),
		.connected_i(conn), .node_reset_i(nreset), .ctl_event_i(evt),
		.ctl_clear_i(clr), .nmt_state_i(nmt), .set_wr_i(set_wr),
		.set_rate_i(rate_in), .set_id_i(id_in), .tim_wr_i(tim_wr),
		.tim_on_i(t_on), .tim_off_i(t_off), .tim_blink_i(t_blk),
		.tim_gap_i(t_gap), .led_red_o(red), .led_green_o(grn),
		.rate_o(rate), .node_id_o(id), .id_reject_o(rej));
	cosi_master_model u_master (.clk_i(clk), .link_i(link), .cmd_i(cmd),
		.miss_i(miss), .conn_o(conn), .nmt_o(nmt), .event_o(evt));

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// lit cycles and rising edges of both lamps over n cycles
	task automatic lamps(int n);
		logic [7:0] a, b, c, d;
		logic       pr, pg;
		{a, b, c, d} = 32'h0;
		pr = red;
		pg = grn;
		repeat (n) begin
			step(1);
			a += {7'h0, red};
			b += {7'h0, red & ~pr};
			c += {7'h0, grn};
			d += {7'h0, grn & ~pg};
			pr = red;
			pg = grn;
		end
		cnt = {a, b, c, d};
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic t_red();
		link = 1'b1;
		cmd = 2'h3;
		warn = 1'b1;
		step(30);
		lamps(48);
		chk("warn", cnt, {8'h10, 8'h4, 8'h20, 8'h4});
		miss = 1'b1;
		step(1);
		miss = 1'b0;
		step(30);
		lamps(54);
		chk("guard", cnt, {8'h18, 8'h6, 8'h1e, 8'h6});
		// event and clear land on one edge: the event must win
		miss = 1'b1;
		step(1);
		miss = 1'b0;
		clr = 1'b1;
		step(1);
		clr = 1'b0;
		step(4);
		lamps(54);
		chk("set wins", cnt, {8'h18, 8'h6, 8'h1e, 8'h6});
		bus_off = 1'b1;
		step(12);
		lamps(40);
		chk("bus off", cnt, {8'h28, 8'h0, 8'h0, 8'h0});
		bus_off = 1'b0;
		warn = 1'b0;
		clr = 1'b1;
		step(1);
		clr = 1'b0;
		step(12);
		lamps(40);
		chk("clear", cnt, {8'h0, 8'h0, 8'h28, 8'h0});
	endtask

	task automatic t_green();
		cmd = 2'h1;
		step(20);
		lamps(48);
		chk("preop", cnt, {8'h0, 8'h0, 8'h18, 8'h6});
		cmd = 2'h2;
		step(20);
		lamps(48);
		chk("stopped", cnt, {8'h0, 8'h0, 8'h10, 8'h4});
		nreset = 1'b1;
		step(12);
		lamps(24);
		chk("node reset", cnt, 32'h0);
		nreset = 1'b0;
		cmd = 2'h0;
		step(8);
		lamps(24);
		chk("init", cnt, 32'h0);
		link = 1'b0;
		cmd = 2'h3;
		step(12);
		lamps(24);
		chk("no link", cnt, 32'h0);
	endtask

	task automatic t_set();
		link = 1'b1;
		step(12);
		arst_n = 1'b0;
		step(2);
		chk("mid reset", {red, grn, rate, id}, {2'h0, 3'h3, 7'h01});
		arst_n = 1'b1;
		step(4);
		for (int i = 0; i < 8; i++) begin
			set_wr = 1'b1;
			rate_in = i[2:0];
			id_in = 7'h7f - i[6:0];
			step(1);
			chk("rate", rate, i);
			chk("id", {rej, id}, 8'h7f - i);
		end
		id_in = 7'h00;
		step(1);
		set_wr = 1'b0;
		chk("id zero", {rej, id, rate}, {1'b1, 7'h78, 3'h7});
	endtask

	task automatic t_tim();
		tim_wr = 1'b1;
		step(1);
		tim_wr = 1'b0;
		cmd = 2'h2;
		step(20);
		lamps(48);
		chk("timing", cnt, {8'h0, 8'h0, 8'h12, 8'h3});
	endtask

	initial begin
		{arst_n, warn, bus_off, nreset, clr, set_wr, tim_wr, link, miss} = '0;
		cmd = 2'h0;
		rate_in = 3'h0;
		id_in = 7'h00;
		{t_on, t_off, t_blk, t_gap} = {24'h6, 24'ha, 24'h4, 24'h2};
		errors = 0;
		check_count = 0;
		step(20);
		arst_n = 1'b1;
		step(4);
		chk("reset", {rate, id, rej, red, grn}, {3'h3, 7'h01, 3'h0});
		t_red();
		t_green();
		t_set();
		t_tim();
		tally_and_finish();
	end

	// hang guard
	initial begin
		#200us;
		errors++;
		tally_and_finish();
	end
endmodule

bind cosi_top cosi_top_monitor u_mon (.*);
